// *** logic/cpst_defines.vh ***
/*
 constants for the cpu state block: register offsets, status bit positions,
 reset values, memory map bounds and alu command codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef CPST_DEFINES_VH
`define CPST_DEFINES_VH
// avalon register byte offsets
`define CPST_OFS_IP 8'h00
`define CPST_OFS_ACC 8'h04
`define CPST_OFS_TACC 8'h08
`define CPST_OFS_IDX 8'h0c
`define CPST_OFS_XPTR 8'h10
`define CPST_OFS_SPTR 8'h14
`define CPST_OFS_PSW 8'h18
`define CPST_OFS_ALU 8'h1c
`define CPST_OFS_BANKADR 8'h20
`define CPST_OFS_MAPQ 8'h24
`define CPST_OFS_WIN 8'h40
// reset values
`define CPST_IP_RST 16'hfffd
`define CPST_CC_RST 8'h30
// condition code bit positions
`define CPST_CC_H 7
`define CPST_CC_I 6
`define CPST_CC_IL_HI 5
`define CPST_CC_IL_LO 4
`define CPST_CC_N 3
`define CPST_CC_Z 2
`define CPST_CC_V 1
`define CPST_CC_C 0
// memory map, 64 kbyte space
`define CPST_IO_END 16'h007f
`define CPST_PROG_BASE 16'h8000
`define CPST_VECT_BASE 16'hffc0
`define CPST_BANK_BASE 16'h0100
`define CPST_REG_DATA 2'h0
`define CPST_REG_IO 2'h1
`define CPST_REG_PROG 2'h2
`define CPST_REG_VECT 2'h3
// alu commands
`define CPST_OP_ADD 3'h0
`define CPST_OP_SUB 3'h1
`define CPST_OP_ADDC 3'h2
`define CPST_OP_SUBC 3'h3
`define CPST_OP_SHL 3'h4
`define CPST_OP_SHR 3'h5
`define CPST_OP_AND 3'h6
`define CPST_OP_CMP 3'h7
`endif

// *** logic/cpst_flag_unit.v ***
/*
 8-bit arithmetic and shift unit producing the result and condition flags.
 assumes operands come from flops on the same clock; purely combinational.
*/
`include "cpst_defines.vh"
module cpst_flag_unit (
    // operands
    input wire [2:0] op_i,
    input wire [7:0] a_i,
    input wire [7:0] b_i,
    input wire cin_i,
    // result and flags
    output reg [7:0] res_o,
    output reg h_o,
    output reg v_o,
    output reg c_o,
    output wire n_o,
    output wire z_o,
    output reg arith_o
);
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] bx;
    reg cx;
    // result and per-op flags
    always @* begin
        sum = 9'h000;
        nib = 5'h00;
        bx = b_i;
        cx = 1'b0;
        res_o = 8'h00;
        h_o = 1'b0;
        v_o = 1'b0;
        c_o = 1'b0;
        arith_o = 1'b1;
        case (op_i)
            `CPST_OP_SHL: begin
                res_o = {a_i[6:0], cin_i};
                c_o = a_i[7];
                arith_o = 1'b0;
            end
            `CPST_OP_SHR: begin
                res_o = {cin_i, a_i[7:1]};
                c_o = a_i[0];
                arith_o = 1'b0;
            end
            `CPST_OP_AND: begin
                res_o = a_i & b_i;
                arith_o = 1'b0;
            end
            default: begin
                // subtraction as a + ~b + 1 (a + ~b + ~carry for subc), borrow is inverted carry
                if (op_i == `CPST_OP_SUB || op_i == `CPST_OP_SUBC || op_i == `CPST_OP_CMP) begin
                    bx = ~b_i;
                    cx = (op_i == `CPST_OP_SUBC) ? ~cin_i : 1'b1;
                    nib = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
                    sum = {1'b0, a_i} + {1'b0, bx} + {8'h00, cx};
                    h_o = ~nib[4];
                    c_o = ~sum[8];
                end else begin
                    cx = (op_i == `CPST_OP_ADDC) ? cin_i : 1'b0;
                    nib = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
                    sum = {1'b0, a_i} + {1'b0, bx} + {8'h00, cx};
                    h_o = nib[4];
                    c_o = sum[8];
                end
                res_o = sum[7:0];
                v_o = (a_i[7] == bx[7]) && (sum[7] != a_i[7]);
            end
        endcase
    end
    assign n_o = res_o[7];
    assign z_o = (res_o == 8'h00);
endmodule // cpst_flag_unit

// *** logic/cpst_bank_ram.v ***
/*
 register bank storage: 16 banks of eight 8-bit general registers.
 assumes one access per cycle; read data come out of a register.
*/
module cpst_bank_ram (
    // clock
    input wire clk_i,
    // access port
    input wire [6:0] addr_i,
    input wire wr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o
);
    reg [7:0] mem [0:127];
    // synchronous write and registered read
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule // cpst_bank_ram

// *** logic/cpst_core.v ***
/*
 architectural state of the 8-bit cpu core: instruction pointer, accumulators,
 pointers, status word with condition codes, banked general registers,
 memory map decode and interrupt admission, reached over avalon-mm.
 assumes a single clock, synchronous active-high reset, and a master that
 holds each request until waitrequest is seen low.
*/
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`include "cpst_defines.vh"
module cpst_core (
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    // avalon-mm slave
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // core control
    input wire step_i,
    input wire irq_req_i,
    input wire [1:0] irq_level_i,
    output reg irq_take_o,
    output reg [1:0] ip_region_o
);
    // architectural registers
    reg [15:0] instruction_pointer;
    reg [15:0] acc;
    reg [15:0] tacc;
    reg [15:0] index_register;
    reg [15:0] extra_pointer;
    reg [15:0] stack_pointer;
    reg [7:0] bank_pointer;
    reg [7:0] condition_code_byte;
    reg [15:0] map_query;
    // bus handshake state
    reg busy;
    reg [31:0] rdata;
    reg win_rd;
    wire [15:0] program_status_word;
    wire req;
    wire ack;
    wire wr_ack;
    wire win_sel;
    wire [6:0] ram_addr;
    wire [7:0] ram_q;
    wire [2:0] alu_op;
    wire [7:0] alu_res;
    wire alu_h;
    wire alu_v;
    wire alu_c;
    wire alu_n;
    wire alu_z;
    wire alu_arith;
    wire [7:0] next_cc;

    // region of a 64 kbyte address: io lowest, data above, program above that, vectors at top
    function [1:0] region_of;
        input [15:0] addr;
        begin
            if (addr <= `CPST_IO_END) begin
                region_of = `CPST_REG_IO;
            end else if (addr >= `CPST_VECT_BASE) begin
                region_of = `CPST_REG_VECT;
            end else if (addr >= `CPST_PROG_BASE) begin
                region_of = `CPST_REG_PROG;
            end else begin
                region_of = `CPST_REG_DATA;
            end
        end
    endfunction

    // byte-enable merge into a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] be;
        begin
            merge16[7:0] = be[0] ? nw[7:0] : old[7:0];
            merge16[15:8] = be[1] ? nw[15:8] : old[15:8];
        end
    endfunction

    // address of a general register in the active bank
    function [15:0] bank_addr;
        input [3:0] bank;
        input [2:0] r;
        begin
            bank_addr = `CPST_BANK_BASE + {9'h000, bank, r};
        end
    endfunction

    // status word halves
    assign program_status_word = {bank_pointer, condition_code_byte};

    // every access takes one wait cycle, answered on the second edge
    assign req = avs_read_i | avs_write_i;
    assign ack = req & busy;
    assign wr_ack = ack & avs_write_i;
    assign avs_waitrequest_o = req & ~busy;

    // general register window, bank chosen by the bank pointer
    assign win_sel = ({5'h00, avs_address_i[7:5]} == (`CPST_OFS_WIN >> 5)) && (avs_address_i[1:0] == 2'h0);
    assign ram_addr = {bank_pointer[3:0], avs_address_i[4:2]};

    cpst_bank_ram u_bank_ram (
        .clk_i(clk_i),
        .addr_i(ram_addr),
        .wr_i(wr_ack & win_sel & avs_byteenable_i[0]),
        .wdata_i(avs_writedata_i[7:0]),
        .rdata_o(ram_q)
    );

    // alu works on the low bytes of both accumulators
    assign alu_op = avs_writedata_i[2:0];

    cpst_flag_unit u_flag_unit (
        .op_i(alu_op),
        .a_i(acc[7:0]),
        .b_i(tacc[7:0]),
        .cin_i(condition_code_byte[`CPST_CC_C]),
        .res_o(alu_res),
        .h_o(alu_h),
        .v_o(alu_v),
        .c_o(alu_c),
        .n_o(alu_n),
        .z_o(alu_z),
        .arith_o(alu_arith)
    );

    // flags after an alu command; interrupt bits untouched
    assign next_cc = {
        alu_arith ? alu_h : condition_code_byte[`CPST_CC_H],
        condition_code_byte[`CPST_CC_I],
        condition_code_byte[`CPST_CC_IL_HI:`CPST_CC_IL_LO],
        alu_n,
        alu_z,
        alu_v,
        alu_c
    };

    // handshake: busy for the answer cycle only
    always @(posedge clk_i) begin
        if (reset_i) begin
            busy <= 1'b0;
        end else if (ack) begin
            busy <= 1'b0;
        end else if (req) begin
            busy <= 1'b1;
        end
    end

    // control state: pointer and status word
    always @(posedge clk_i) begin
        if (reset_i) begin
            instruction_pointer <= `CPST_IP_RST;
            condition_code_byte <= `CPST_CC_RST;
            bank_pointer <= 8'h00;
            map_query <= 16'h0000;
        end else begin
            if (wr_ack && avs_address_i == `CPST_OFS_IP) begin
                instruction_pointer <= merge16(instruction_pointer, avs_writedata_i[15:0],
                    avs_byteenable_i[1:0]);
            end else if (step_i) begin
                instruction_pointer <= instruction_pointer + 16'h0001;
            end
            if (wr_ack && avs_address_i == `CPST_OFS_PSW) begin
                if (avs_byteenable_i[0]) begin
                    condition_code_byte <= avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    bank_pointer <= avs_writedata_i[15:8];
                end
            end else if (wr_ack && avs_address_i == `CPST_OFS_ALU && avs_byteenable_i[0]) begin
                condition_code_byte <= next_cc;
            end
            if (wr_ack && avs_address_i == `CPST_OFS_MAPQ) begin
                map_query <= merge16(map_query, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
            end
        end
    end

    // data registers, undefined until software writes them
    always @(posedge clk_i) begin
        if (wr_ack) begin
            case (avs_address_i)
                `CPST_OFS_ACC: begin
                    acc <= merge16(acc, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
                end
                `CPST_OFS_TACC: begin
                    tacc <= merge16(tacc, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
                end
                `CPST_OFS_IDX: begin
                    index_register <= merge16(index_register, avs_writedata_i[15:0],
                        avs_byteenable_i[1:0]);
                end
                `CPST_OFS_XPTR: begin
                    extra_pointer <= merge16(extra_pointer, avs_writedata_i[15:0],
                        avs_byteenable_i[1:0]);
                end
                `CPST_OFS_SPTR: begin
                    stack_pointer <= merge16(stack_pointer, avs_writedata_i[15:0],
                        avs_byteenable_i[1:0]);
                end
                `CPST_OFS_ALU: begin
                    // result lands in the low byte, compare keeps it
                    if (avs_byteenable_i[0] && alu_op != `CPST_OP_CMP) begin
                        acc[7:0] <= alu_res;
                    end
                end
                default: begin
                    acc <= acc;
                end
            endcase
        end
    end

    // read data captured on the edge that ends the wait cycle
    always @(posedge clk_i) begin
        if (reset_i) begin
            rdata <= 32'h00000000;
            win_rd <= 1'b0;
        end else if (avs_read_i && !busy) begin
            win_rd <= win_sel;
            case (avs_address_i)
                `CPST_OFS_IP: rdata <= {16'h0000, instruction_pointer};
                `CPST_OFS_ACC: rdata <= {16'h0000, acc};
                `CPST_OFS_TACC: rdata <= {16'h0000, tacc};
                `CPST_OFS_IDX: rdata <= {16'h0000, index_register};
                `CPST_OFS_XPTR: rdata <= {16'h0000, extra_pointer};
                `CPST_OFS_SPTR: rdata <= {16'h0000, stack_pointer};
                `CPST_OFS_PSW: rdata <= {16'h0000, program_status_word};
                `CPST_OFS_BANKADR: rdata <= {16'h0000, bank_addr(bank_pointer[3:0], 3'h0)};
                `CPST_OFS_MAPQ: rdata <= {14'h0, region_of(map_query), map_query};
                default: rdata <= 32'h00000000;
            endcase
        end
    end

    // window reads come straight from the ram output register
    assign avs_readdata_o = win_rd ? {24'h000000, ram_q} : rdata;

    // interrupt admission and instruction pointer region
    always @(posedge clk_i) begin
        if (reset_i) begin
            irq_take_o <= 1'b0;
            ip_region_o <= `CPST_REG_VECT;
        end else begin
            irq_take_o <= irq_req_i
                && condition_code_byte[`CPST_CC_I]
                && (irq_level_i < condition_code_byte[`CPST_CC_IL_HI:`CPST_CC_IL_LO]);
            ip_region_o <= region_of(instruction_pointer);
        end
    end
endmodule // cpst_core

// *** tb/cpst_core_assertions.sv ***
/*
 checker for cpst_core: reset outputs, bus pacing, map and bank reads,
 interrupt admission. assumes requests are held until waitrequest is low.
*/
module cpst_core_sva (
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    // bus
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    // core control
    input wire irq_req_i,
    input wire [1:0] irq_level_i,
    input wire irq_take_o,
    input wire [1:0] ip_region_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic psw_wr;
    logic [2:0] irq_ctl;
    wire rd_ok = avs_read_i && !avs_waitrequest_o;
    // region code of an address
    function automatic logic [1:0] rgn(input logic [15:0] a);
        rgn = (a <= 16'h007f) ? 2'h1 : (a < 16'h8000) ? 2'h0 : (a < 16'hffc0) ? 2'h2 : 2'h3;
    endfunction
    // status word written since reset
    always @(posedge clk_i) begin
        if (reset_i) psw_wr <= 1'b0;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h18) psw_wr <= 1'b1;
    end
    // interrupt enable and level field as last written to the status word
    always @(posedge clk_i) begin
        if (reset_i) irq_ctl <= 3'h3;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h18 && avs_byteenable_i[0])
            irq_ctl <= avs_writedata_i[6:4];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_rst; $fell(reset_i) |-> avs_readdata_o == 32'h0 && !irq_take_o && ip_region_o == 2'h3; endproperty
    a_rst: assert property (p_rst) else $error("outputs wrong after reset");
    property p_psw_rst; rd_ok && avs_address_i == 8'h18 && !psw_wr |-> avs_readdata_o[6:4] == 3'h3; endproperty
    a_psw_rst: assert property (p_psw_rst) else $error("status reset bits wrong");
    property p_irq_en; !$past(reset_i) |-> irq_take_o == ($past(irq_req_i) && $past(irq_ctl[2])
        && ($past(irq_level_i) < $past(irq_ctl[1:0]))); endproperty
    a_irq_en: assert property (p_irq_en) else $error("interrupt taken while blocked");
    property p_irq_lvl; $past(irq_level_i) == 2'h3 |-> !irq_take_o; endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("lowest level request taken");
    property p_map; rd_ok && avs_address_i == 8'h24 |-> avs_readdata_o[17:16] == rgn(avs_readdata_o[15:0])
        && avs_readdata_o[31:18] == 14'h0; endproperty
    a_map: assert property (p_map) else $error("map region wrong");
    property p_bank; rd_ok && avs_address_i == 8'h20 |-> avs_readdata_o >= 32'h100
        && avs_readdata_o <= 32'h178 && avs_readdata_o[2:0] == 3'h0; endproperty
    a_bank: assert property (p_bank) else $error("bank base out of range");
    property p_wide; rd_ok && avs_address_i < 8'h1c |-> avs_readdata_o[31:16] == 16'h0; endproperty
    a_wide: assert property (p_wide) else $error("register wider than 16 bits");
    property p_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("access not one wait state");
endmodule // cpst_core_sva
bind cpst_core cpst_core_sva u_sva (.clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_req_i, .irq_level_i,
    .irq_take_o, .ip_region_o);

// *** tb/cpst_core_tb.sv ***
/*
 self-checking bench for cpst_core with an integer reference model.
 assumes one 40 MHz clock and a synchronous active-high reset.
*/
module cpst_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0, step_i = 0, irq_req_i = 0;
    logic [7:0] avs_address_i = 8'h0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [1:0] irq_level_i = 2'h0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, irq_take_o;
    wire [1:0] ip_region_o;
    int num_errors = 0, checks = 0;
    int a, b, c, e, h, v, cy, op, s, ci, m, k;
    logic [15:0] rnd = 16'h0041;
    logic [31:0] rd;
    logic [15:0] ma[6] = '{16'h007f, 16'h0080, 16'h7fff, 16'h8000, 16'hffbf, 16'hffc0};
    logic [1:0] mr[6] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3};
    // 25 ns clock
    always #12.5 clk_i = ~clk_i;
    cpst_core DUT (.clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .step_i, .irq_req_i, .irq_level_i,
        .irq_take_o, .ip_region_o);
    // pseudo-random source
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    // one bus access, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] be);
        logic w;
        int n;
        n = 0;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_address_i <= ad;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        // sample at the rising edge; the answering edge also carries read data
        do begin
            @(posedge clk_i);
            w = avs_waitrequest_o;
            rd = avs_readdata_o;
            n++;
        end while (w !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("[ERR] waitrequest expected 0 seen %b", w);
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        bus(1'b1, ad, wd, 4'h3);
    endtask
    task automatic rdc(input string n, input logic [7:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, 32'h0, 4'h3);
        chk(n, exp, rd);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog, far beyond the expected run
    initial begin
        #500000;
        num_errors++;
        $display("[ERR] watchdog expected end seen hang");
        print_verdict;
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rdc("ip", 8'h00, 32'hfffd);
        bus(1'b0, 8'h18, 32'h0, 4'h3);
        chk("cc_irq", 32'h30, rd & 32'h70);
        chk("region", 32'h3, {30'h0, ip_region_o});
        $display("reset test done");
        for (k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            wr(8'(4 * k), {16'h0, rnd});
            bus(1'b1, 8'(4 * k), {16'h0, ~rnd}, 4'h1);
            rdc("reg", 8'(4 * k), {16'h0, rnd[15:8], ~rnd[7:0]});
        end
        wr(8'h30, 32'hffff);
        rdc("unmapped", 8'h30, 32'h0);
        $display("register test done");
        foreach (ma[i]) begin
            wr(8'h24, {16'h0, ma[i]});
            rdc("map", 8'h24, {14'h0, mr[i], ma[i]});
            wr(8'h00, {16'h0, ma[i]});
            @(posedge clk_i);
            @(negedge clk_i);
            chk("region", {30'h0, mr[i]}, {30'h0, ip_region_o});
            @(posedge clk_i);
        end
        wr(8'h00, 32'h1234);
        step_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        step_i <= 1'b0;
        @(posedge clk_i);
        rdc("ip_step", 8'h00, 32'h1239);
        $display("map test done");
        for (k = 0; k < 16; k += 5) begin
            wr(8'h18, {20'h0, 4'(k), 8'h0});
            rdc("bank_base", 8'h20, 32'(32'h100 + 8 * k));
            wr(8'h5c, 32'(k + 32'ha0));
        end
        for (k = 0; k < 16; k += 5) begin
            wr(8'h18, {20'h0, 4'(k), 8'h0});
            rdc("bank_reg", 8'h5c, 32'(k + 32'ha0));
        end
        $display("bank test done");
        // alu model: a is the accumulator, b the temporary accumulator
        for (k = 0; k < 32; k++) begin
            rnd = lfsr(rnd);
            a = rnd[7:0];
            b = rnd[15:8];
            c = (k >> 3) & 1;
            op = k & 7;
            s = (op == 1 || op == 3 || op == 7);
            ci = (op == 2 || op == 3) ? c : 0;
            e = s ? a - b - ci : a + b + ci;
            h = s ? ((a & 15) - (b & 15) - ci) < 0 : ((a & 15) + (b & 15) + ci) > 15;
            v = s ? ((a ^ b) & (a ^ e) & 128) != 0 : (~(a ^ b) & (a ^ e) & 128) != 0;
            cy = (e >> 8) & 1;
            if (op >= 4 && op <= 6) begin
                v = 0;
                h = 0;
            end
            if (op == 4) begin
                e = a * 2 + c;
                cy = a >> 7;
            end
            if (op == 5) begin
                e = c * 128 + a / 2;
                cy = a & 1;
            end
            if (op == 6) e = a & b;
            m = (op == 6) ? 32'hfe : 32'hff;
            wr(8'h04, 32'(a));
            wr(8'h08, 32'(b));
            wr(8'h18, 32'(32'h30 + c));
            bus(1'b1, 8'h1c, 32'(op), 4'h1);
            rdc("alu_res", 8'h04, 32'((op == 7) ? a : e & 255));
            bus(1'b0, 8'h18, 32'h0, 4'h3);
            chk("alu_flags", 32'(m & (h * 128 + 48 + ((e >> 7) & 1) * 8 + ((e & 255) == 0) * 4 + v * 2 + cy)),
                rd & 32'(m));
        end
        $display("alu test done");
        for (k = 0; k < 32; k++) begin
            wr(8'h18, 32'(((k >> 4) & 1) * 64 + ((k >> 2) & 3) * 16));
            irq_req_i <= 1'b1;
            irq_level_i <= 2'(k & 3);
            @(posedge clk_i);
            @(negedge clk_i);
            chk("irq_take", 32'(((k >> 4) & 1) && (k & 3) < ((k >> 2) & 3)), {31'h0, irq_take_o});
            @(posedge clk_i);
            irq_req_i <= 1'b0;
        end
        $display("interrupt test done");
        print_verdict;
    end
endmodule // cpst_core_tb
